// File: bench/mfc_builder_model.sv
// Stand-in for the outside pause frame builder.
// Assumes one clock; the bench picks the build latency.
`timescale 1ns/1ps
`default_nettype none
module mfc_builder_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       start_in,
	input  wire logic [3:0] lat_in,
	output var  logic       done_out
);
	int cnt; // Cycles left in the frame
	// ----------------------------------------
	// One done pulse per start, lat_in+1 cycles on
	// ----------------------------------------
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		if (rst_in) begin
			cnt <= 0;
		end else if (start_in) begin
			cnt <= int'(lat_in) + 1;
		end else if (cnt == 1) begin
			done_out <= 1'b1;
			cnt      <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule : mfc_builder_model
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the flow control and link fault block.
// Assumes the builder model answers every generated frame.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic         clk, rst, rd, wr, rxv, txa, done, drop, hold, gst, gbusy, cen;
	logic [7:0]   addr, qen, ind, mind, gqe, mq;
	logic [31:0]  wd, rdata, rxd, mtd, txd;
	logic [3:0]   rxc, mtc, txc, lat;
	logic [15:0]  rty, rop, qgr, gop, txq;
	logic [127:0] rq, gq, q;
	logic [1:0]   cpr, fst;
	logic [47:0]  gda, gsa, sa;
	int           failures, check_count, i, n;
	// Design under test
	mfc_top mfc_top_inst (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(cen),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .rx_ctl_valid_in(rxv), .rx_ctl_type_in(rty),
		.rx_ctl_opcode_in(rop), .rx_ctl_qen_in(qen), .rx_ctl_quanta_in(rq),
		.rx_ctl_drop_out(drop), .tx_frame_active_in(txa), .tx_pause_hold_out(hold),
		.client_pause_request_in(cpr), .queue_pause_gen_request_in(qgr),
		.queue_pause_indication_out(ind), .gen_done_in(done), .gen_start_out(gst),
		.gen_busy_out(gbusy), .gen_dst_addr_out(gda), .gen_src_addr_out(gsa),
		.gen_opcode_out(gop), .gen_qen_out(gqe), .gen_quanta_out(gq),
		.xgmii_rxd_in(rxd), .xgmii_rxc_in(rxc), .mac_txd_in(mtd), .mac_txc_in(mtc),
		.xgmii_txd_out(txd), .xgmii_txc_out(txc), .link_fault_status_out(fst));
	// Far side frame builder
	mfc_builder_model mfc_builder_model_inst (.clk_in(clk), .rst_in(rst),
		.start_in(gst), .lat_in(lat), .done_out(done));
	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr   <= 1'b1;
		addr <= a;
		wd   <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrr
	// Read data stands only in the cycle after the strobe
	task automatic rdx(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e, "read");
	endtask : rdx
	// One decoded control frame, results checked a cycle on
	task automatic rxf(input logic [15:0] op, input logic [7:0] qe, input logic [127:0] qv);
		@(posedge clk);
		rxv <= 1'b1;
		rty <= 16'h8808;
		rop <= op;
		qen <= qe;
		rq  <= qv;
		@(posedge clk);
		rxv <= 1'b0;
		#1;
	endtask : rxf
	// Wait for a generated frame and compare its fields
	task automatic gchk(input logic [15:0] op, input int qi, input logic [15:0] qv);
		#1;
		for (n = 0; n < 60 && gst !== 1'b1; n++) @(posedge clk) #1;
		chk(gst, 1'b1, "start");
		chk(gop, op, "opcode");
		chk(gq[16*qi +: 16], qv, "quanta");
		chk(gda, 48'h010000c28001, "dest");
		chk(gsa, sa, "source");
		@(posedge clk);
	endtask : gchk
	task automatic end_sim;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	// Clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#100us;
		failures++;
		$display("[FAIL] %0t watchdog", $time);
		end_sim();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rd, wr, rxv, txa, addr, wd, qen, rty, rop, rq, cpr, qgr, mind} = '0;
		{rxc, rxd, mtc, mtd} = {4'hf, 32'h07070707, 4'hf, 32'h07070707};
		lat = 4'h2;
		cen = 1'b1;
		rst = 1'b1;
		failures = 0;
		check_count = 0;
		void'($urandom(40));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// Reset values and an unmapped place
		rdx(8'h00, 32'h4);
		rdx(8'h08, 32'hffff);
		rdx(8'h20, 32'hffff);
		wrr(8'hfc, 32'h1);
		rdx(8'hfc, 32'h0);
		// A write with the clock enable low must be lost
		@(posedge clk);
		cen <= 1'b0;
		wrr(8'h08, 32'h1234);
		cen <= 1'b1;
		rdx(8'h08, 32'hffff);
		$display("register test done");
		// Received link pause, ignored then honoured
		wrr(8'h00, 32'h5);
		rxf(16'h0001, 8'h0, 128'h3);
		repeat (3) @(posedge clk);
		#1 chk(hold, 1'b0, "ignored pause");
		wrr(8'h00, 32'h4);
		txa <= 1'b1;
		rxf(16'h0001, 8'h0, 128'h3);
		repeat (3) @(posedge clk);
		#1 chk(hold, 1'b0, "mid frame");
		@(posedge clk);
		txa <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(hold, 1'b1, "paused");
		rxf(16'h0001, 8'h0, 128'h0);
		repeat (3) @(posedge clk);
		#1 chk(hold, 1'b0, "xon");
		rxf(16'h0001, 8'h0, 128'hffff);
		rxf(16'h0001, 8'h0, 128'h2);
		for (i = 0; i < 60 && hold === 1'b1; i++) @(posedge clk) #1;
		chk(hold, 1'b0, "expiry");
		// Two quanta of 16 cycles, at most one quantum early, plus the hold flop
		chk(i >= 16 && i <= 33, 1'b1, "expiry time");
		$display("link pause test done");
		// Generation: trigger beats pins, held pins repeat
		sa = 48'({$urandom, $urandom});
		txq = 16'($urandom);
		@(posedge clk);
		lat <= 4'($urandom_range(1, 8));
		wrr(8'h0c, sa[31:0]);
		wrr(8'h10, {16'h0, sa[47:32]});
		wrr(8'h08, {16'h0, txq});
		wrr(8'h04, 32'h2);
		cpr <= 2'b01;
		gchk(16'h0001, 0, txq);
		gchk(16'h0001, 0, 16'h0);
		gchk(16'h0001, 0, 16'h0);
		cpr <= 2'b00;
		rdx(8'h04, 32'h0);
		wrr(8'h14, 32'hff);
		qgr <= 16'h0002;
		gchk(16'h0101, 1, 16'hffff);
		chk(gqe[1], 1'b1, "queue enable");
		qgr <= 16'h0400;
		gchk(16'h0101, 2, 16'h0);
		chk(gqe[2], 1'b1, "queue xon enable");
		qgr <= 16'h0;
		$display("generation test done");
		// Priority pause reception against the model
		for (i = 0; i < 6; i++) begin
			wrr(8'h00, i[0] ? 32'h6 : 32'h4);
			mq = 8'($urandom);
			for (n = 0; n < 8; n++) begin
				q[16*n +: 16] = ($urandom_range(0, 2) == 0) ? 16'h0 : 16'($urandom_range(256, 65535));
				if (mq[n]) mind[n] = (q[16*n +: 16] != 16'h0);
			end
			rxf(16'h0101, mq, q);
			chk(drop, !i[0], "drop");
			chk(ind, mind, "indication");
		end
		rxf(16'h0101, 8'hff, {8{16'h1}});
		chk(ind, 8'hff, "all paused");
		repeat (40) @(posedge clk);
		#1 chk(ind, 8'h0, "queue expiry");
		$display("priority test done");
		// Local then remote fault, recovery after 128 good columns
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			rxc <= 4'h1;
			rxd <= i ? 32'h9c000002 : 32'h9c000001;
			// Live MAC data, so a fault column cannot pass as it
			mtd <= $urandom;
			mtc <= 4'h0;
			@(posedge clk);
			{rxc, rxd} <= {4'hf, 32'h07070707};
			@(posedge clk);
			#1 chk(fst, i ? 2'b10 : 2'b01, "fault");
			chk(txd, i ? 32'h07070707 : 32'h9c000002, "fault column");
			chk(txc, i ? 4'hf : 4'h1, "fault ctl");
			repeat (120) @(posedge clk);
			#1 chk(fst == 2'b00, 1'b0, "early clear");
			repeat (10) @(posedge clk);
			#1 chk(fst, 2'b00, "cleared");
		end
		repeat (2) @(posedge clk);
		#1 chk({txc, txd}, {mtc, mtd}, "pass through");
		$display("fault test done");
		end_sim();
	end
endmodule : testbench
`default_nettype wire

// File: rtl/mfc_pkg.sv
// Types of the MAC flow-control and link-fault block.
// Assumes the constants header beside it.
package mfc_pkg;
	// Pause frame generator states
	typedef enum logic [0:0] {
		MFC_GEN_IDLE = 1'b0,
		MFC_GEN_BUSY = 1'b1
	} mfc_gen_st_t;
	// Link fault status codes
	typedef enum logic [1:0] {
		MFC_FLT_OK     = 2'b00,
		MFC_FLT_LOCAL  = 2'b01,
		MFC_FLT_REMOTE = 2'b10
	} mfc_fault_t;
endpackage : mfc_pkg

// File: rtl/mfc_regs.svh
// Constants of the MAC flow-control and link-fault block.
// Assumes 32-bit register words at byte offsets, one clock.
`ifndef MFC_REGS_SVH
`define MFC_REGS_SVH
// Operation
// R1: Received XOFF stops transmit for quanta.
// R2: Frame in flight finishes before pausing.
// R3: Resume on XON or timer end.
// R4: New received quanta overwrites pause counter.
// R5: Ignore bit disregards received pause frames.
// R6: Client two-bit request: high XOFF, low XON.
// R7: Requests ignored while generating; repeat while held.
// R8: Client holds request at least one cycle.
// R9: Trigger register wins, clears when carried out.
// R10: XOFF frames carry transmit quanta register.
// R11: Multicast destination, source from station address.
// R12: Two to eight queues, per-queue enable/ignore.
// R13: Priority frames dropped unless forward bit set.
// R14: Queue indication rises on enabled nonzero quanta.
// R15: Queue indication drops on zero or expiry.
// R16: Client stops paused queue after current frame.
// R17: Latest quanta replaces queue pause duration.
// R18: Queue XOFF uses quanta reg, spaced by holdoff.
// R19: Queue XON sends zero quanta.
// R20: Local fault: status 01, send remote fault.
// R21: Remote fault: status 10, send idle.
// R22: Status 00 after over 127 good columns.
// R23: Control frames known by type and opcode.
// R24: Timers count 512-bit-time quanta.
`define MFC_REG_CTRL     8'h00
`define MFC_REG_TRIG     8'h04
`define MFC_REG_TXQ      8'h08
`define MFC_REG_SA_LO    8'h0c
`define MFC_REG_SA_HI    8'h10
`define MFC_REG_PFC_EN   8'h14
`define MFC_REG_PFC_IGN  8'h18
`define MFC_REG_STATUS   8'h1c
`define MFC_REG_PQ_BASE  3'h1
`define MFC_REG_HO_BASE  3'h2
`define MFC_CTRL_IGN     0
`define MFC_CTRL_FWD     1
`define MFC_CTRL_TXEN    2
`define MFC_CTRL_RST     3'h4
`define MFC_TXQ_RST      16'hffff
`define MFC_PQ_RST       16'hffff
`define MFC_HO_RST       16'h0000
`define MFC_TYPE_CTL     16'h8808
`define MFC_OP_PAUSE     16'h0001
`define MFC_OP_PFC       16'h0101
`define MFC_PAUSE_DA     48'h010000c28001
`define MFC_COL_LF       32'h9c000001
`define MFC_COL_RF       32'h9c000002
`define MFC_COL_IDLE     32'h07070707
`define MFC_CTL_SEQ      4'h1
`define MFC_CTL_IDLE     4'hf
`define MFC_GOOD_COLS    8'h7f
`define MFC_QUANTUM_BITS 512
`define MFC_COL_BITS     32
`endif

// File: rtl/mfc_top.sv
// Flow control (pause, priority pause) and link fault logic.
// Assumes decoded receive control-frame fields and an outside
// frame builder that serialises the generated pause frame.
//
// The register addresses and the plain strobed port were left to the implementer.
`include "mfc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module mfc_top #(
	parameter int NQ = 8        // Priority queues, 2 to 8
) (
	input  wire logic          ref_clk_in,
	input  wire logic          sys_rst_in,
	input  wire logic          clk_en_in,
	input  wire logic [7:0]    reg_addr_in,
	input  wire logic [31:0]   reg_wdata_in,
	input  wire logic          reg_wr_in,
	input  wire logic          reg_rd_in,
	output var  logic [31:0]   reg_rdata_out,
	input  wire logic          rx_ctl_valid_in,
	input  wire logic [15:0]   rx_ctl_type_in,
	input  wire logic [15:0]   rx_ctl_opcode_in,
	input  wire logic [7:0]    rx_ctl_qen_in,
	input  wire logic [127:0]  rx_ctl_quanta_in,
	output var  logic          rx_ctl_drop_out,
	input  wire logic          tx_frame_active_in,
	output var  logic          tx_pause_hold_out,
	input  wire logic [1:0]    client_pause_request_in,
	input  wire logic [2*NQ-1:0] queue_pause_gen_request_in,
	output var  logic [NQ-1:0] queue_pause_indication_out,
	input  wire logic          gen_done_in,
	output var  logic          gen_start_out,
	output var  logic          gen_busy_out,
	output var  logic [47:0]   gen_dst_addr_out,
	output var  logic [47:0]   gen_src_addr_out,
	output var  logic [15:0]   gen_opcode_out,
	output var  logic [7:0]    gen_qen_out,
	output var  logic [127:0]  gen_quanta_out,
	input  wire logic [31:0]   xgmii_rxd_in,
	input  wire logic [3:0]    xgmii_rxc_in,
	input  wire logic [31:0]   mac_txd_in,
	input  wire logic [3:0]    mac_txc_in,
	output var  logic [31:0]   xgmii_txd_out,
	output var  logic [3:0]    xgmii_txc_out,
	output var  logic [1:0]    link_fault_status_out
);
	// ------------------------------------------------
	// Declarations
	// ------------------------------------------------
	localparam int QC = `MFC_QUANTUM_BITS / `MFC_COL_BITS;
	logic [2:0]  ctrl_r;        // Ignore, forward, tx enable
	logic [1:0]  trig_r;        // Software pause trigger
	logic [15:0] txq_r;         // Transmit pause quanta
	logic [31:0] sa_lo_r;       // Station address low
	logic [15:0] sa_hi_r;       // Station address high
	logic [NQ-1:0] pfc_en_r;    // Per-queue transmit enable
	logic [NQ-1:0] pfc_ign_r;   // Per-queue receive ignore
	logic [15:0] pq_cfg_r [NQ]; // Per-queue XOFF quanta
	logic [15:0] ho_cfg_r [NQ]; // Per-queue holdoff
	logic [15:0] rq_r [NQ];     // Per-queue receive timers
	logic [15:0] ho_r [NQ];     // Per-queue holdoff timers
	logic [NQ-1:0] ho_zero;     // Holdoff expired
	logic [NQ-1:0] qxoff;       // Queue XOFF asks now
	logic [NQ-1:0] qxon;        // Queue XON asks now
	logic [7:0]  qcnt_r;        // Quantum prescaler
	logic        tick;          // One quantum elapsed
	logic [15:0] pq_r;          // Link pause timer
	logic        paused;        // Link pause running
	logic        is_ctl;        // Control frame strobe
	logic        is_pause;      // Link pause frame
	logic        is_pfc;        // Priority pause frame
	logic [1:0]  cli_req;       // Gated client request
	logic        wr_trig;       // Trigger written now
	mfc_pkg::mfc_gen_st_t gen_st_r;
	mfc_pkg::mfc_fault_t  flt_r;
	logic [7:0]  good_r;        // Good column run
	logic        col_lf;        // Local fault column
	logic        col_rf;        // Remote fault column
	logic [2:0]  qidx;          // Queue register index
	logic        q_hit;         // Index names a queue

	// ------------------------------------------------
	// Frame classification
	// ------------------------------------------------
	// Type 0x8808 then opcode picks pause or priority
	assign is_ctl   = rx_ctl_valid_in && rx_ctl_type_in == `MFC_TYPE_CTL; // R23
	assign is_pause = is_ctl && rx_ctl_opcode_in == `MFC_OP_PAUSE; // R23
	assign is_pfc   = is_ctl && rx_ctl_opcode_in == `MFC_OP_PFC; // R23
	assign qidx     = reg_addr_in[4:2];
	assign q_hit    = 32'(qidx) < NQ;
	assign wr_trig  = reg_wr_in && reg_addr_in == `MFC_REG_TRIG;

	// Drop link pause always; priority pause unless forwarded
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			rx_ctl_drop_out <= 1'b0;
		end else if (clk_en_in) begin
			rx_ctl_drop_out <= is_pause ||
				(is_pfc && !ctrl_r[`MFC_CTRL_FWD]); // R13
		end
	end

	// ------------------------------------------------
	// Quantum tick
	// ------------------------------------------------
	// One shared prescaler: a freshly loaded timer may end
	// up to one quantum early, traded for fewer counters
	assign tick = qcnt_r == 8'(QC - 1);
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			qcnt_r <= 8'h00;
		end else if (clk_en_in) begin
			qcnt_r <= tick ? 8'h00 : qcnt_r + 8'h01; // R24
		end
	end

	// ------------------------------------------------
	// Register writes
	// ------------------------------------------------
	// Plain configuration words
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			ctrl_r    <= `MFC_CTRL_RST;
			txq_r     <= `MFC_TXQ_RST;
			sa_lo_r   <= 32'h00000000;
			sa_hi_r   <= 16'h0000;
			pfc_en_r  <= '0;
			pfc_ign_r <= '0;
		end else if (clk_en_in && reg_wr_in) begin
			if (reg_addr_in == `MFC_REG_CTRL) begin
				ctrl_r <= reg_wdata_in[2:0];
			end else if (reg_addr_in == `MFC_REG_TXQ) begin
				txq_r <= reg_wdata_in[15:0];
			end else if (reg_addr_in == `MFC_REG_SA_LO) begin
				sa_lo_r <= reg_wdata_in;
			end else if (reg_addr_in == `MFC_REG_SA_HI) begin
				sa_hi_r <= reg_wdata_in[15:0];
			end else if (reg_addr_in == `MFC_REG_PFC_EN) begin
				pfc_en_r <= reg_wdata_in[NQ-1:0]; // R12
			end else if (reg_addr_in == `MFC_REG_PFC_IGN) begin
				pfc_ign_r <= reg_wdata_in[NQ-1:0]; // R12
			end
		end
	end

	// Trigger clears once its frame starts; a write in the
	// same cycle wins so a fresh request is never lost
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			trig_r <= 2'b00;
		end else if (clk_en_in) begin
			if (wr_trig) begin
				trig_r <= reg_wdata_in[1:0];
			end else if (gen_st_r == mfc_pkg::MFC_GEN_IDLE) begin
				trig_r <= 2'b00; // R9
			end
		end
	end

	// ------------------------------------------------
	// Register reads
	// ------------------------------------------------
	// Data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (clk_en_in) begin
			reg_rdata_out <= 32'h00000000;
			if (!reg_rd_in) begin
				reg_rdata_out <= 32'h00000000;
			end else if (reg_addr_in == `MFC_REG_CTRL) begin
				reg_rdata_out[2:0] <= ctrl_r;
			end else if (reg_addr_in == `MFC_REG_TRIG) begin
				reg_rdata_out[1:0] <= trig_r;
			end else if (reg_addr_in == `MFC_REG_TXQ) begin
				reg_rdata_out[15:0] <= txq_r;
			end else if (reg_addr_in == `MFC_REG_SA_LO) begin
				reg_rdata_out <= sa_lo_r;
			end else if (reg_addr_in == `MFC_REG_SA_HI) begin
				reg_rdata_out[15:0] <= sa_hi_r;
			end else if (reg_addr_in == `MFC_REG_PFC_EN) begin
				reg_rdata_out[NQ-1:0] <= pfc_en_r;
			end else if (reg_addr_in == `MFC_REG_PFC_IGN) begin
				reg_rdata_out[NQ-1:0] <= pfc_ign_r;
			end else if (reg_addr_in == `MFC_REG_STATUS) begin
				// Live state: hold, fault, busy, queues, timer
				reg_rdata_out[0]     <= tx_pause_hold_out;
				reg_rdata_out[2:1]   <= flt_r;
				reg_rdata_out[3]     <= gen_busy_out;
				reg_rdata_out[NQ+7:8] <= queue_pause_indication_out;
				reg_rdata_out[31:16] <= pq_r;
			end else if (reg_addr_in[7:5] == `MFC_REG_PQ_BASE && q_hit) begin
				reg_rdata_out[15:0] <= pq_cfg_r[qidx];
			end else if (reg_addr_in[7:5] == `MFC_REG_HO_BASE && q_hit) begin
				reg_rdata_out[15:0] <= ho_cfg_r[qidx];
			end
		end
	end

	// ------------------------------------------------
	// Link pause on receive
	// ------------------------------------------------
	// Latest quanta overwrites the timer; zero is XON
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			pq_r <= 16'h0000;
		end else if (clk_en_in) begin
			if (is_pause && !ctrl_r[`MFC_CTRL_IGN]) begin // R5
				pq_r <= rx_ctl_quanta_in[15:0]; // R1 R3 R4
			end else if (tick && pq_r != 16'h0000) begin
				pq_r <= pq_r - 16'h0001; // R3 R24
			end
		end
	end
	assign paused = pq_r != 16'h0000;

	// Hold only rises between frames, so the frame on the
	// wire always completes before transmit stops
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			tx_pause_hold_out <= 1'b0;
		end else if (clk_en_in) begin
			tx_pause_hold_out <= paused &&
				(tx_pause_hold_out || !tx_frame_active_in); // R2
		end
	end

	// ------------------------------------------------
	// Per-queue timers and configuration
	// ------------------------------------------------
	for (genvar n = 0; n < NQ; n++) begin : g_q
		// Queue quanta and holdoff registers
		always_ff @(posedge ref_clk_in) begin
			if (sys_rst_in) begin
				pq_cfg_r[n] <= `MFC_PQ_RST;
				ho_cfg_r[n] <= `MFC_HO_RST;
			end else if (clk_en_in && reg_wr_in && qidx == 3'(n)) begin
				if (reg_addr_in[7:5] == `MFC_REG_PQ_BASE) begin
					pq_cfg_r[n] <= reg_wdata_in[15:0];
				end else if (reg_addr_in[7:5] == `MFC_REG_HO_BASE) begin
					ho_cfg_r[n] <= reg_wdata_in[15:0];
				end
			end
		end
		// Receive timer: enabled slot reloads, else counts
		always_ff @(posedge ref_clk_in) begin
			if (sys_rst_in) begin
				rq_r[n] <= 16'h0000;
			end else if (clk_en_in) begin
				if (is_pfc && rx_ctl_qen_in[n] && !pfc_ign_r[n]) begin
					rq_r[n] <= rx_ctl_quanta_in[16*n +: 16]; // R17
				end else if (tick && rq_r[n] != 16'h0000) begin
					rq_r[n] <= rq_r[n] - 16'h0001; // R24
				end
			end
		end
		// Indication follows the timer; client obeys it (R16)
		always_ff @(posedge ref_clk_in) begin
			if (sys_rst_in) begin
				queue_pause_indication_out[n] <= 1'b0;
			end else if (clk_en_in) begin
				if (is_pfc && rx_ctl_qen_in[n] && !pfc_ign_r[n]) begin
					queue_pause_indication_out[n] <=
						rx_ctl_quanta_in[16*n +: 16] != 16'h0000; // R14 R15
				end else if (tick && rq_r[n] == 16'h0001) begin
					queue_pause_indication_out[n] <= 1'b0; // R15
				end
			end
		end
		// Holdoff: next XOFF for queue waits for zero
		always_ff @(posedge ref_clk_in) begin
			if (sys_rst_in) begin
				ho_r[n] <= 16'h0000;
			end else if (clk_en_in) begin
				if (gen_st_r == mfc_pkg::MFC_GEN_IDLE && trig_r == 2'b00
						&& cli_req == 2'b00 && qxoff[n]) begin
					ho_r[n] <= ho_cfg_r[n]; // R18
				end else if (tick && ho_r[n] != 16'h0000) begin
					ho_r[n] <= ho_r[n] - 16'h0001;
				end
			end
		end
		assign ho_zero[n] = ho_r[n] == 16'h0000;
		assign qxoff[n] = queue_pause_gen_request_in[n] && pfc_en_r[n]
			&& ho_zero[n]; // R18
		assign qxon[n] = queue_pause_gen_request_in[NQ+n] && pfc_en_r[n];
	end

	// ------------------------------------------------
	// Pause frame generation
	// ------------------------------------------------
	// Client pins count only with link pause enabled
	assign cli_req = ctrl_r[`MFC_CTRL_TXEN] ? client_pause_request_in : 2'b00; // R6

	// Idle takes one request: trigger, then pins, then
	// queues. Busy ignores all until the builder is done.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			gen_st_r         <= mfc_pkg::MFC_GEN_IDLE;
			gen_start_out    <= 1'b0;
			gen_busy_out     <= 1'b0;
			gen_dst_addr_out <= 48'h000000000000;
			gen_src_addr_out <= 48'h000000000000;
			gen_opcode_out   <= 16'h0000;
			gen_qen_out      <= 8'h00;
			gen_quanta_out   <= '0;
		end else if (clk_en_in) begin
			gen_start_out <= 1'b0;
			case (gen_st_r)
				mfc_pkg::MFC_GEN_IDLE: begin
					gen_dst_addr_out <= `MFC_PAUSE_DA; // R11
					gen_src_addr_out <= {sa_hi_r, sa_lo_r}; // R11
					gen_qen_out      <= 8'h00;
					gen_quanta_out   <= '0;
					if (trig_r != 2'b00) begin
						// Register first, then pins
						gen_st_r       <= mfc_pkg::MFC_GEN_BUSY; // R9
						gen_start_out  <= 1'b1;
						gen_busy_out   <= 1'b1;
						gen_opcode_out <= `MFC_OP_PAUSE;
						gen_quanta_out[15:0] <= trig_r[1] ? txq_r : 16'h0000; // R10
					end else if (cli_req != 2'b00) begin
						// XOFF wins when both bits stand
						gen_st_r       <= mfc_pkg::MFC_GEN_BUSY; // R6 R7
						gen_start_out  <= 1'b1;
						gen_busy_out   <= 1'b1;
						gen_opcode_out <= `MFC_OP_PAUSE;
						gen_quanta_out[15:0] <= cli_req[1] ? txq_r : 16'h0000; // R10
					end else if ((qxoff | qxon) != '0) begin
						gen_st_r       <= mfc_pkg::MFC_GEN_BUSY;
						gen_start_out  <= 1'b1;
						gen_busy_out   <= 1'b1;
						gen_opcode_out <= `MFC_OP_PFC;
						for (int n = 0; n < NQ; n++) begin
							gen_qen_out[n] <= qxoff[n] || qxon[n]; // R18 R19
							gen_quanta_out[16*n +: 16] <=
								qxoff[n] ? pq_cfg_r[n] : 16'h0000; // R18 R19
						end
					end
				end
				mfc_pkg::MFC_GEN_BUSY: begin
					if (gen_done_in) begin
						gen_st_r     <= mfc_pkg::MFC_GEN_IDLE; // R7
						gen_busy_out <= 1'b0;
					end
				end
				default: begin
					gen_st_r     <= mfc_pkg::MFC_GEN_IDLE;
					gen_busy_out <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------
	// Reconciliation: link fault
	// ------------------------------------------------
	assign col_lf = xgmii_rxc_in == `MFC_CTL_SEQ && xgmii_rxd_in == `MFC_COL_LF;
	assign col_rf = xgmii_rxc_in == `MFC_CTL_SEQ && xgmii_rxd_in == `MFC_COL_RF;

	// Any fault column restarts the good-column run
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			flt_r  <= mfc_pkg::MFC_FLT_OK;
			good_r <= 8'h00;
		end else if (clk_en_in) begin
			if (col_lf) begin
				flt_r  <= mfc_pkg::MFC_FLT_LOCAL; // R20
				good_r <= 8'h00;
			end else if (col_rf) begin
				flt_r  <= mfc_pkg::MFC_FLT_REMOTE; // R21
				good_r <= 8'h00;
			end else if (flt_r != mfc_pkg::MFC_FLT_OK) begin
				if (good_r == `MFC_GOOD_COLS) begin
					flt_r  <= mfc_pkg::MFC_FLT_OK; // R22
					good_r <= 8'h00;
				end else begin
					good_r <= good_r + 8'h01;
				end
			end
		end
	end

	// Remote fault columns (local fault) or idle columns (remote fault) replace MAC data, which is lost
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			xgmii_txd_out <= `MFC_COL_IDLE;
			xgmii_txc_out <= `MFC_CTL_IDLE;
			link_fault_status_out <= 2'b00;
		end else if (clk_en_in) begin
			link_fault_status_out <= flt_r;
			if (flt_r == mfc_pkg::MFC_FLT_LOCAL) begin
				xgmii_txd_out <= `MFC_COL_RF; // R20
				xgmii_txc_out <= `MFC_CTL_SEQ;
			end else if (flt_r == mfc_pkg::MFC_FLT_REMOTE) begin
				xgmii_txd_out <= `MFC_COL_IDLE; // R21
				xgmii_txc_out <= `MFC_CTL_IDLE;
			end else begin
				xgmii_txd_out <= mac_txd_in;
				xgmii_txc_out <= mac_txc_in;
			end
		end
	end

	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	default clocking dc @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_lf_seen;
		clk_en_in && col_lf;
	endsequence
	sequence s_two_en;
		clk_en_in ##1 clk_en_in;
	endsequence

	pause_load_a: assert property ( // R4
		clk_en_in && is_pause && !ctrl_r[`MFC_CTRL_IGN]
		|=> pq_r == $past(rx_ctl_quanta_in[15:0]))
		else $error("pause timer not loaded");
	ignore_pause_a: assert property ( // R5
		clk_en_in && is_pause && ctrl_r[`MFC_CTRL_IGN]
		|=> pq_r <= $past(pq_r))
		else $error("ignored pause changed timer");
	hold_between_a: assert property ( // R2
		$rose(tx_pause_hold_out) |-> $past(!tx_frame_active_in))
		else $error("hold rose mid frame");
	resume_now_a: assert property ( // R3
		clk_en_in && pq_r == 16'h0000 |=> !tx_pause_hold_out)
		else $error("hold stayed after pause end");
	trig_first_a: assert property ( // R9
		clk_en_in && gen_st_r == mfc_pkg::MFC_GEN_IDLE && trig_r[1]
		|=> gen_start_out && gen_quanta_out[15:0] == $past(txq_r))
		else $error("trigger xoff not sent");
	busy_ignore_a: assert property ( // R7
		gen_start_out && $past(clk_en_in) |-> !$past(gen_busy_out))
		else $error("start while busy");
	frame_addr_a: assert property ( // R11
		gen_start_out |-> gen_dst_addr_out == `MFC_PAUSE_DA
		&& gen_src_addr_out == {$past(sa_hi_r), $past(sa_lo_r)})
		else $error("pause frame address wrong");
	queue_rise_a: assert property ( // R14
		clk_en_in && is_pfc && rx_ctl_qen_in[0] && !pfc_ign_r[0]
		&& rx_ctl_quanta_in[15:0] != 16'h0000
		|=> queue_pause_indication_out[0])
		else $error("queue indication missing");
	pfc_drop_a: assert property ( // R13
		clk_en_in && is_pfc |=> rx_ctl_drop_out == !$past(ctrl_r[1]))
		else $error("priority frame drop wrong");
	local_fault_a: assert property ( // R20
		s_lf_seen ##0 s_two_en |=> xgmii_txd_out == `MFC_COL_RF)
		else $error("remote fault not sent");
endmodule : mfc_top
`default_nettype wire
